/* src/prescaled_timekeeper_alarm.sv */
module prescaled_timekeeper_alarm
    import timekeeper_pkg::*;
#(
    parameter int DETECT_WINDOW = DETECT_WIN
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    input wire logic LOW_FREQ_OSC_INPUT,
    input wire logic POWERDOWN,
    output logic TICK_IRQ,
    output logic ALARM_IRQ,
    output logic FAST_EXT_IRQ,
    output logic PD_WAKE,
    output logic MAIN_OSC_EN,
    output logic LF_OSC_EN
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] timekeeper_control;
    logic [CTRL_W-1:0] next_timekeeper_control;
    logic [SYS_W-1:0] system_config_reg;
    logic [SYS_W-1:0] next_system_config_reg;
    logic [DIV_W-1:0] basic_period_reload;
    logic [DIV_W-1:0] next_basic_period_reload;
    logic [DIV_W-1:0] divider;
    logic [DIV_W-1:0] next_divider;
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] next_counter;
    logic [CNT_W-1:0] alarm;
    logic [CNT_W-1:0] next_alarm;
    logic [CNT_W-1:0] ntick_reload;
    logic [CNT_W-1:0] next_ntick_reload;
    logic [CNT_W-1:0] ntick_count;
    logic [CNT_W-1:0] next_ntick_count;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] next_status;
    logic [DATA_W-1:0] next_rdata;
    logic next_tick_irq;
    logic next_alarm_irq;
    logic next_fast_irq;
    logic next_wake;
    logic next_main_en;
    logic next_lf_en;
    logic lf_meta;
    logic lf_sync;
    logic pd_meta;
    logic pd_sync;
    logic pre_strobe;
    logic lf_selected;
    logic decided;
    logic tick;
    logic running;
    logic [57:0] long_timer;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lf_meta <= 1'b0;
            lf_sync <= 1'b0;
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
        end else begin
            lf_meta <= LOW_FREQ_OSC_INPUT;
            lf_sync <= lf_meta;
            pd_meta <= POWERDOWN;
            pd_sync <= pd_meta;
        end
    end

    // ------------------------------------------------------------
    // Source detection and prescaler
    // ------------------------------------------------------------
    lf_detector #(
        .WINDOW(DETECT_WINDOW)
    ) u_detect (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .lf_sync(lf_sync),
        .lf_selected(lf_selected),
        .decided(decided)
    );

    // Counting stops in power down unless asked to keep running
    assign running = timekeeper_control[CTRL_RUN] && decided &&
        (!pd_sync || timekeeper_control[CTRL_PD_RUN]);

    pulse_prescaler #(
        .DIVIDE(PRE_DIV)
    ) u_pre (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .enable(running),
        .strobe(pre_strobe)
    );

    // Basic tick: prescaler strobe while the divider sits at zero
    assign tick = pre_strobe && (divider == '0);
    // Low prescaler bits are not exposed
    assign long_timer = {counter, divider, PRE_W'(0)};

    // ------------------------------------------------------------
    // Counter chain
    // ------------------------------------------------------------
    always_comb begin
        next_divider = divider;
        next_counter = counter;
        next_ntick_count = ntick_count;
        next_status = status;
        next_status[ST_LF] = lf_selected;
        // Write-one clear first, so that a set below in the same cycle wins
        if (WR && ADDR == OFF_STATUS) begin
            next_status[ST_NTICK:ST_TICK] = status[ST_NTICK:ST_TICK] &
                ~WDATA[ST_NTICK:ST_TICK];
        end
        if (pre_strobe) begin
            if (divider == '0) begin
                next_divider = basic_period_reload;
            end else begin
                next_divider = divider - 1'b1;
            end
        end
        if (tick) begin
            next_counter = counter + 1'b1;
            next_status[ST_TICK] = 1'b1;
            if (ntick_count == '0) begin
                next_ntick_count = ntick_reload;
                next_status[ST_NTICK] = 1'b1;
            end else begin
                next_ntick_count = ntick_count - 1'b1;
            end
        end
        if (counter == alarm && tick) begin
            next_status[ST_ALARM] = 1'b1;
        end
        if (WR && ADDR == OFF_DIV) begin
            next_divider = WDATA[DIV_W-1:0];
        end
        if (WR && ADDR == OFF_CNT) begin
            next_counter = WDATA[CNT_W-1:0];
        end
        if (WR && ADDR == OFF_NTICK) begin
            next_ntick_count = WDATA[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb begin
        next_timekeeper_control = timekeeper_control;
        next_system_config_reg = system_config_reg;
        next_basic_period_reload = basic_period_reload;
        next_alarm = alarm;
        next_ntick_reload = ntick_reload;
        if (WR) begin
            case (ADDR)
                OFF_CTRL: next_timekeeper_control = WDATA[CTRL_W-1:0];
                OFF_RELOAD: next_basic_period_reload = WDATA[DIV_W-1:0];
                OFF_ALARM: next_alarm = WDATA[CNT_W-1:0];
                OFF_NTICK: next_ntick_reload = WDATA[CNT_W-1:0];
                OFF_SYSCFG: next_system_config_reg = WDATA[SYS_W-1:0];
                default: next_alarm = alarm;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        if (RD) begin
            case (ADDR)
                OFF_CTRL: next_rdata = DATA_W'(timekeeper_control);
                OFF_RELOAD: next_rdata = DATA_W'(basic_period_reload);
                // Divider and counter read through the long timer
                OFF_DIV: next_rdata = DATA_W'(long_timer[PRE_W +: DIV_W]);
                OFF_CNT: next_rdata = long_timer[PRE_W + DIV_W +: CNT_W];
                OFF_ALARM: next_rdata = alarm;
                OFF_NTICK: next_rdata = ntick_reload;
                OFF_STATUS: next_rdata = DATA_W'(status);
                OFF_SYSCFG: next_rdata = DATA_W'(system_config_reg);
                default: next_rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Requests and oscillator enables
    // ------------------------------------------------------------
    always_comb begin
        next_tick_irq = status[ST_TICK] && timekeeper_control[CTRL_TICK_EN];
        next_alarm_irq = status[ST_ALARM] && timekeeper_control[CTRL_ALARM_EN];
        next_fast_irq = (next_tick_irq && system_config_reg[SYS_SRC_TICK]) ||
            (next_alarm_irq && system_config_reg[SYS_SRC_ALARM]) ||
            (status[ST_NTICK] && timekeeper_control[CTRL_NTICK_EN]);
        // Wake on any fast request in power down only when allowed
        next_wake = pd_sync && next_fast_irq && system_config_reg[SYS_PD_WAKE];
        next_main_en = 1'b1;
        next_lf_en = 1'b1;
        // Oscillator enables follow the chosen source in power down
        if (pd_sync) begin
            if (!timekeeper_control[CTRL_RUN]) begin
                next_main_en = 1'b0;
                next_lf_en = 1'b0;
            end else if (lf_selected) begin
                next_main_en = 1'b0;
                next_lf_en = !timekeeper_control[CTRL_OSC_OFF];
            end else begin
                next_main_en = !timekeeper_control[CTRL_OSC_OFF];
                next_lf_en = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Software-written configuration
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timekeeper_control <= CTRL_RESET;
            system_config_reg <= SYS_RESET;
            basic_period_reload <= RELOAD_RESET;
            alarm <= '0;
            ntick_reload <= NTICK_RESET;
        end else begin
            timekeeper_control <= next_timekeeper_control;
            system_config_reg <= next_system_config_reg;
            basic_period_reload <= next_basic_period_reload;
            alarm <= next_alarm;
            ntick_reload <= next_ntick_reload;
        end
    end

    // Counter chain and status flags
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            divider <= '0;
            counter <= '0;
            ntick_count <= '0;
            status <= '0;
        end else begin
            divider <= next_divider;
            counter <= next_counter;
            ntick_count <= next_ntick_count;
            status <= next_status;
        end
    end

    // Read data, standing one cycle after a read
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= '0;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // Requests, wake and oscillator enables
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TICK_IRQ <= 1'b0;
            ALARM_IRQ <= 1'b0;
            FAST_EXT_IRQ <= 1'b0;
            PD_WAKE <= 1'b0;
            MAIN_OSC_EN <= 1'b1;
            LF_OSC_EN <= 1'b1;
        end else begin
            TICK_IRQ <= next_tick_irq;
            ALARM_IRQ <= next_alarm_irq;
            FAST_EXT_IRQ <= next_fast_irq;
            PD_WAKE <= next_wake;
            MAIN_OSC_EN <= next_main_en;
            LF_OSC_EN <= next_lf_en;
        end
    end
endmodule // prescaled_timekeeper_alarm

/* src/timekeeper_pkg.sv */
package timekeeper_pkg;
    // ------------------------------------------------------------
    // Prescaler ratio and widths
    // ------------------------------------------------------------
    localparam int PRE_DIV = 64;
    localparam int PRE_W = 6;
    localparam int DIV_W = 20;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int ACT_W = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_DIV = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_CNT = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_ALARM = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_NTICK = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_SYSCFG = 4'h7;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_TICK_EN = 1;
    localparam int CTRL_ALARM_EN = 2;
    localparam int CTRL_NTICK_EN = 3;
    localparam int CTRL_OSC_OFF = 4;
    localparam int CTRL_PD_RUN = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h01;

    // Status fields
    localparam int ST_TICK = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_NTICK = 2;
    localparam int ST_LF = 3;
    localparam int ST_W = 4;

    // System configuration fields
    localparam int SYS_PD_WAKE = 0;
    localparam int SYS_SRC_TICK = 1;
    localparam int SYS_SRC_ALARM = 2;
    localparam int SYS_W = 3;
    localparam logic [SYS_W-1:0] SYS_RESET = 3'h0;

    localparam logic [DIV_W-1:0] RELOAD_RESET = 20'h00000;
    localparam logic [CNT_W-1:0] NTICK_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // Low-frequency detection at reset
    // ------------------------------------------------------------
    localparam int DETECT_EDGES = 4;
    localparam int DETECT_WIN = 4096;

    typedef enum logic [2:0] {
        DET_WAIT = 3'b001,
        DET_LF = 3'b010,
        DET_MAIN = 3'b100
    } detect_e;
endpackage

/* src/pulse_prescaler.sv */
module pulse_prescaler
    import timekeeper_pkg::*;
#(
    parameter int DIVIDE = PRE_DIV
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable,
    output logic strobe
);
    logic [PRE_W-1:0] count;
    logic [PRE_W-1:0] next_count;
    logic next_strobe;

    // ------------------------------------------------------------
    // Fixed divider
    // ------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_strobe = 1'b0;
        if (enable) begin
            if (count == PRE_W'(DIVIDE - 1)) begin
                next_count = '0;
                next_strobe = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            strobe <= 1'b0;
        end else begin
            count <= next_count;
            strobe <= next_strobe;
        end
    end
endmodule // pulse_prescaler

/* src/lf_detector.sv */
module lf_detector
    import timekeeper_pkg::*;
#(
    parameter int WINDOW = DETECT_WIN
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic lf_sync,
    output logic lf_selected,
    output logic decided
);
    detect_e state;
    detect_e next_state;
    logic [12:0] win;
    logic [12:0] next_win;
    logic [2:0] edges;
    logic [2:0] next_edges;
    logic lf_prev;

    // ------------------------------------------------------------
    // Count low-frequency edges in a window after reset
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_win = win;
        next_edges = edges;
        case (state)
            DET_WAIT: begin
                next_win = win + 1'b1;
                if (lf_sync && !lf_prev) begin
                    next_edges = edges + 1'b1;
                end
                if (edges == 3'(DETECT_EDGES)) begin
                    next_state = DET_LF;
                end else if (win == 13'(WINDOW)) begin
                    next_state = DET_MAIN;
                end
            end
            DET_LF: next_state = DET_LF;
            DET_MAIN: next_state = DET_MAIN;
            default: next_state = DET_WAIT;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= DET_WAIT;
            win <= '0;
            edges <= '0;
            lf_prev <= 1'b0;
        end else begin
            state <= next_state;
            win <= next_win;
            edges <= next_edges;
            lf_prev <= lf_sync;
        end
    end

    assign lf_selected = (state == DET_LF);
    assign decided = (state != DET_WAIT);
endmodule // lf_detector

/* test/prescaled_timekeeper_alarm_properties.sv */
module prescaled_timekeeper_alarm_properties
    import timekeeper_pkg::*;
#(
    parameter int DETECT_WINDOW = DETECT_WIN
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic LOW_FREQ_OSC_INPUT,
    input wire logic POWERDOWN,
    input wire logic TICK_IRQ,
    input wire logic ALARM_IRQ,
    input wire logic FAST_EXT_IRQ,
    input wire logic PD_WAKE,
    input wire logic MAIN_OSC_EN,
    input wire logic LF_OSC_EN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    // ------------------------------------------------------------
    // Bus and request flags
    // ------------------------------------------------------------
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == '0)
        else $error("read data not zero outside read answer");
    tick_hold_a: assert property ($fell(TICK_IRQ) |-> $past(WR) || $past(WR, 2) || $past(WR, 3))
        else $error("tick request dropped without a write");
    alarm_hold_a: assert property ($fell(ALARM_IRQ) |-> $past(WR) || $past(WR, 2) || $past(WR, 3))
        else $error("alarm request dropped without a write");
    fast_hold_a: assert property ($fell(FAST_EXT_IRQ) |-> $past(WR) || $past(WR, 2) || $past(WR, 3))
        else $error("fast request dropped without a write");

    // ------------------------------------------------------------
    // Power down
    // ------------------------------------------------------------
    pd_wake_idle_a: assert property (!POWERDOWN [*4] |=> !PD_WAKE)
        else $error("wake outside power down");
    wake_fast_a: assert property (PD_WAKE |-> FAST_EXT_IRQ && $past(POWERDOWN, 3))
        else $error("wake without fast request");
    osc_awake_a: assert property (!POWERDOWN [*4] |=> MAIN_OSC_EN && LF_OSC_EN)
        else $error("oscillator off while awake");
    osc_single_a: assert property (POWERDOWN [*4] |=> !(MAIN_OSC_EN && LF_OSC_EN))
        else $error("both oscillators on in power down");

    tick_seen_c: cover property ($rose(TICK_IRQ));
    alarm_seen_c: cover property ($rose(ALARM_IRQ));
    wake_seen_c: cover property ($rose(PD_WAKE));
endmodule // prescaled_timekeeper_alarm_properties

/* test/prescaled_timekeeper_alarm_tb.sv */
module prescaled_timekeeper_alarm_tb
    import timekeeper_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WIN = 64;
    logic SYS_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [DATA_W-1:0] WDATA = '0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic LOW_FREQ_OSC_INPUT = 1'b0;
    logic POWERDOWN = 1'b0;
    logic lf_on = 1'b0;
    logic [DATA_W-1:0] RDATA;
    logic TICK_IRQ, ALARM_IRQ, FAST_EXT_IRQ, PD_WAKE, MAIN_OSC_EN, LF_OSC_EN;
    logic [3:0] prev_irq = '0;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int last_rise [4];
    int gap [4];
    wire [3:0] irqs = {PD_WAKE, FAST_EXT_IRQ, ALARM_IRQ, TICK_IRQ};

    prescaled_timekeeper_alarm #(.DETECT_WINDOW(WIN)) i_dut (
        .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .LOW_FREQ_OSC_INPUT(LOW_FREQ_OSC_INPUT), .POWERDOWN(POWERDOWN),
        .TICK_IRQ(TICK_IRQ), .ALARM_IRQ(ALARM_IRQ), .FAST_EXT_IRQ(FAST_EXT_IRQ),
        .PD_WAKE(PD_WAKE), .MAIN_OSC_EN(MAIN_OSC_EN), .LF_OSC_EN(LF_OSC_EN)
    );

    initial begin
        forever #20 SYS_CLK = ~SYS_CLK;
    end

    // ------------------------------------------------------------
    // Rise-to-rise spacing of requests, low-frequency source
    // ------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        prev_irq <= irqs;
        if (lf_on) LOW_FREQ_OSC_INPUT <= ~LOW_FREQ_OSC_INPUT;
        for (int i = 0; i < 4; i++) begin
            if (irqs[i] && !prev_irq[i]) begin
                gap[i] <= cyc - last_rise[i];
                last_rise[i] <= cyc;
            end
        end
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                         input logic [DATA_W-1:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        @(posedge SYS_CLK);
        check(RDATA & m, e);
    endtask

    // Waits for one request, then clears the tick, alarm and n-tick status flags
    task automatic catch_irq(input int sel);
        int k;
        repeat (3) @(posedge SYS_CLK);
        for (k = 0; k < 3000; k++) begin
            @(posedge SYS_CLK);
            if (irqs[sel] === 1'b1) break;
        end
        if (k == 3000) begin
            n_mismatch++;
            report_and_stop();
        end else begin
            wr(OFF_STATUS, 32'h7);
        end
    endtask

    initial begin
        repeat (12) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        repeat (WIN + 16) @(posedge SYS_CLK);
        rdchk(OFF_CTRL, '1, 32'(CTRL_RESET));
        rdchk(OFF_RELOAD, '1, 32'h0);
        rdchk(4'h8, '1, 32'h0);
        rdchk(OFF_STATUS, 32'h8, 32'h0);
        wr(OFF_CTRL, 32'h03);
        for (int r = 0; r < 3; r++) begin
            wr(OFF_RELOAD, 32'(r));
            repeat (3) catch_irq(0);
            check(32'(gap[0]), 32'(64 * (r + 1)));
        end
        wr(OFF_CTRL, 32'h07);
        wr(OFF_ALARM, 32'h10);
        catch_irq(0);
        wr(OFF_CNT, 32'hffffffff);
        catch_irq(0);
        rdchk(OFF_CNT, '1, 32'h0);
        check(32'(ALARM_IRQ), 32'h0);
        wr(OFF_SYSCFG, 32'h4);
        wr(OFF_CNT, 32'h10);
        catch_irq(1);
        check(32'(last_rise[2]), 32'(last_rise[1]));
        rdchk(OFF_CNT, '1, 32'h11);
        rdchk(OFF_DIV, '1, 32'h2);
        wr(OFF_CTRL, 32'h09);
        wr(OFF_NTICK, 32'h2);
        repeat (3) catch_irq(2);
        check(32'(gap[2]), 32'(3 * 192));
        wr(OFF_SYSCFG, 32'h2);
        wr(OFF_CTRL, 32'h03);
        repeat (3) catch_irq(2);
        check(32'(gap[2]), 32'(192));
        wr(OFF_CTRL, 32'h23);
        wr(OFF_SYSCFG, 32'h3);
        POWERDOWN <= 1'b1;
        catch_irq(3);
        check(32'({MAIN_OSC_EN, LF_OSC_EN}), 32'h2);
        wr(OFF_SYSCFG, 32'h2);
        repeat (400) @(posedge SYS_CLK);
        check(32'({FAST_EXT_IRQ, PD_WAKE}), 32'h2);
        wr(OFF_CTRL, 32'h33);
        repeat (6) @(posedge SYS_CLK);
        check(32'(MAIN_OSC_EN), 32'h0);
        wr(OFF_CTRL, 32'h0);
        repeat (6) @(posedge SYS_CLK);
        check(32'({MAIN_OSC_EN, LF_OSC_EN}), 32'h0);
        POWERDOWN <= 1'b0;
        lf_on <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        ARST_N <= 1'b0;
        repeat (12) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        repeat (WIN + 16) @(posedge SYS_CLK);
        rdchk(OFF_STATUS, 32'h8, 32'h8);
        POWERDOWN <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        check(32'({MAIN_OSC_EN, LF_OSC_EN}), 32'h1);
        wr(OFF_CTRL, 32'h11);
        repeat (6) @(posedge SYS_CLK);
        check(32'(LF_OSC_EN), 32'h0);
        POWERDOWN <= 1'b0;
        report_and_stop();
    end
endmodule // prescaled_timekeeper_alarm_tb

bind prescaled_timekeeper_alarm prescaled_timekeeper_alarm_properties #(
    .DETECT_WINDOW(DETECT_WINDOW)
) i_props (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LOW_FREQ_OSC_INPUT(LOW_FREQ_OSC_INPUT), .POWERDOWN(POWERDOWN),
    .TICK_IRQ(TICK_IRQ), .ALARM_IRQ(ALARM_IRQ), .FAST_EXT_IRQ(FAST_EXT_IRQ),
    .PD_WAKE(PD_WAKE), .MAIN_OSC_EN(MAIN_OSC_EN), .LF_OSC_EN(LF_OSC_EN)
);
